/* core/gpioi_port.sv */
// 32-bit gpio port with apb registers and per-bit interrupts
`timescale 1ns/1ps
`default_nettype none
`include "gpioi_defs.svh"
module gpioi_port #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    reset_n_in,
  // apb slave
  input  wire gpioi_pkg::gpioi_apb_req_s apb_req_in,
  output gpioi_pkg::gpioi_apb_rsp_s    apb_rsp_out,
  // pads
  input  wire logic [WIDTH-1:0]        pad_in,
  output logic [WIDTH-1:0]             pad_out,
  output logic [WIDTH-1:0]             pad_oe_out,
  // combined interrupt
  output logic                         irq_out
);
  import gpioi_pkg::*;

  // software-visible registers, interrupt state and bus answer
  logic [WIDTH-1:0] output_data;
  logic [WIDTH-1:0] pad_direction;
  logic [WIDTH-1:0] irq_enable;
  logic [WIDTH-1:0] irq_mask;
  logic [WIDTH-1:0] irq_type_select;
  logic [WIDTH-1:0] irq_polarity_select;
  logic [WIDTH-1:0] debounce_enable;
  logic             level_sync_enable;
  logic [WIDTH-1:0] edge_latch;
  logic [WIDTH-1:0] prev_sample;
  logic [WIDTH-1:0] level_raw;
  logic [WIDTH-1:0] pad_sync;
  logic [WIDTH-1:0] pad_cond;
  logic [31:0]      rdata;
  logic             irq;
  logic             rsp_ready;

  // next values of every flop
  logic [WIDTH-1:0] next_output_data;
  logic [WIDTH-1:0] next_pad_direction;
  logic [WIDTH-1:0] next_irq_enable;
  logic [WIDTH-1:0] next_irq_mask;
  logic [WIDTH-1:0] next_irq_type_select;
  logic [WIDTH-1:0] next_irq_polarity_select;
  logic [WIDTH-1:0] next_debounce_enable;
  logic             next_level_sync_enable;
  logic [WIDTH-1:0] next_edge_latch;
  logic [WIDTH-1:0] next_prev_sample;
  logic [WIDTH-1:0] next_level_raw;
  logic [31:0]      next_rdata;
  logic             next_irq;
  logic             next_rsp_ready;

  // combinational views and bus decode
  logic [WIDTH-1:0] raw_status;
  logic [WIDTH-1:0] masked_status;
  logic [WIDTH-1:0] level_src;
  logic [WIDTH-1:0] detect_ok;
  logic             wr_en;
  logic             rd_en;
  logic [WIDTH-1:0] clr_bits;
  // per-bit detector hits
  logic [WIDTH-1:0] edge_hit;
  logic [WIDTH-1:0] level_hit;

  // per-pad synchroniser and debouncer
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_cond
      gpioi_input_cond u_cond (
        .core_clk_in    (core_clk_in),
        .reset_n_in     (reset_n_in),
        .pad_in         (pad_in[g]),
        .debounce_en_in (debounce_enable[g]),
        .sync_out       (pad_sync[g]),
        .cond_out       (pad_cond[g])
      );
      // transition of the selected polarity on an enabled input bit
      assign edge_hit[g]  = detect_ok[g] & (pad_cond[g] != prev_sample[g]) &
                            (pad_cond[g] == irq_polarity_select[g]);
      // active level on an enabled input bit; output bits raise none
      assign level_hit[g] = detect_ok[g] & (level_src[g] == irq_polarity_select[g]);
    end
  endgenerate

  // apb decode: writes in the access phase, reads in the setup phase; every access completes in its access cycle
  assign wr_en    = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite;
  assign rd_en    = apb_req_in.psel & ~apb_req_in.pwrite;
  assign clr_bits = (wr_en && apb_req_in.paddr == `GPIOI_OFF_EDGE_CLR) ?
                    apb_req_in.pwdata[WIDTH-1:0] : '0;

  // status views
  assign raw_status    = edge_latch | level_raw;
  assign masked_status = raw_status & ~irq_mask;
  // detection only for enabled input bits
  assign detect_ok     = irq_enable & ~pad_direction;
  // level sources bypass or use the synchroniser; debounce still applies
  // the bypass path reads the pin raw, so it suits only slow, clean sources
  assign level_src     = level_sync_enable ? pad_cond
                         : (pad_in & ~debounce_enable) | (pad_cond & debounce_enable);

  // register writes
  always_comb
  begin
    next_output_data         = output_data;
    next_pad_direction       = pad_direction;
    next_irq_enable          = irq_enable;
    next_irq_mask            = irq_mask;
    next_irq_type_select     = irq_type_select;
    next_irq_polarity_select = irq_polarity_select;
    next_debounce_enable     = debounce_enable;
    next_level_sync_enable   = level_sync_enable;
    if (wr_en)
    begin
      unique case (apb_req_in.paddr)
        `GPIOI_OFF_OUT_DATA:  next_output_data = apb_req_in.pwdata[WIDTH-1:0];
        `GPIOI_OFF_DIRECTION: next_pad_direction = apb_req_in.pwdata[WIDTH-1:0];
        `GPIOI_OFF_IRQ_EN:    next_irq_enable = apb_req_in.pwdata[WIDTH-1:0];
        `GPIOI_OFF_IRQ_MASK:  next_irq_mask = apb_req_in.pwdata[WIDTH-1:0];
        `GPIOI_OFF_IRQ_TYPE:  next_irq_type_select = apb_req_in.pwdata[WIDTH-1:0];
        `GPIOI_OFF_IRQ_POL:   next_irq_polarity_select = apb_req_in.pwdata[WIDTH-1:0];
        `GPIOI_OFF_DEBOUNCE:  next_debounce_enable = apb_req_in.pwdata[WIDTH-1:0];
        `GPIOI_OFF_LVL_SYNC:  next_level_sync_enable = apb_req_in.pwdata[`GPIOI_SYNC_BIT];
        default:              next_output_data = output_data;
      endcase
    end
  end

  // interrupt detection per bit; a disabled bit always holds a clear latch
  always_comb
  begin
    next_prev_sample = pad_cond;
    next_edge_latch  = edge_latch;
    next_level_raw   = '0;
    next_irq         = |masked_status;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (!irq_enable[i])
      begin
        next_edge_latch[i] = 1'b0;
      end
      else if (irq_type_select[i])
      begin
        // set wins over a same-cycle clear so no edge is lost
        if (clr_bits[i])
          next_edge_latch[i] = 1'b0;
        if (edge_hit[i])
          next_edge_latch[i] = 1'b1;
      end
      else
      begin
        // clear writes never reach a level bit; it follows its source
        next_edge_latch[i] = 1'b0;
        next_level_raw[i]  = level_hit[i];
      end
    end
  end

  // read data mux and ready
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (rd_en && !apb_req_in.penable)
    begin
      unique case (apb_req_in.paddr)
        `GPIOI_OFF_OUT_DATA:  next_rdata[WIDTH-1:0] = output_data;
        `GPIOI_OFF_DIRECTION: next_rdata[WIDTH-1:0] = pad_direction;
        `GPIOI_OFF_IRQ_EN:    next_rdata[WIDTH-1:0] = irq_enable;
        `GPIOI_OFF_IRQ_MASK:  next_rdata[WIDTH-1:0] = irq_mask;
        `GPIOI_OFF_IRQ_TYPE:  next_rdata[WIDTH-1:0] = irq_type_select;
        `GPIOI_OFF_IRQ_POL:   next_rdata[WIDTH-1:0] = irq_polarity_select;
        `GPIOI_OFF_MSK_STAT:  next_rdata[WIDTH-1:0] = masked_status;
        `GPIOI_OFF_RAW_STAT:  next_rdata[WIDTH-1:0] = raw_status;
        `GPIOI_OFF_DEBOUNCE:  next_rdata[WIDTH-1:0] = debounce_enable;
        `GPIOI_OFF_PAD_IN:    next_rdata[WIDTH-1:0] = pad_sync;
        `GPIOI_OFF_LVL_SYNC:  next_rdata[`GPIOI_SYNC_BIT] = level_sync_enable;
        default:              next_rdata = 32'h0000_0000;
      endcase
    end
    else if (rsp_ready)
      next_rdata = 32'h0000_0000;
    else
      next_rdata = rdata;
    // ready answers the setup cycle, so no access ever waits
    next_rsp_ready = apb_req_in.psel & ~apb_req_in.penable;
  end

  // register stage of the software-visible registers
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      output_data         <= `GPIOI_RESET_WORD;
      pad_direction       <= `GPIOI_RESET_WORD;
      irq_enable          <= `GPIOI_RESET_WORD;
      irq_mask            <= `GPIOI_RESET_WORD;
      irq_type_select     <= `GPIOI_RESET_WORD;
      irq_polarity_select <= `GPIOI_RESET_WORD;
      debounce_enable     <= `GPIOI_RESET_WORD;
      level_sync_enable   <= 1'b0;
    end
    else
    begin
      output_data         <= next_output_data;
      pad_direction       <= next_pad_direction;
      irq_enable          <= next_irq_enable;
      irq_mask            <= next_irq_mask;
      irq_type_select     <= next_irq_type_select;
      irq_polarity_select <= next_irq_polarity_select;
      debounce_enable     <= next_debounce_enable;
      level_sync_enable   <= next_level_sync_enable;
    end
  end

  // register stage of the interrupt state; a flopped line cannot glitch
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      edge_latch          <= '0;
      prev_sample         <= '0;
      level_raw           <= '0;
      irq                 <= 1'b0;
    end
    else
    begin
      edge_latch          <= next_edge_latch;
      prev_sample         <= next_prev_sample;
      level_raw           <= next_level_raw;
      irq                 <= next_irq;
    end
  end

  // register stage of the bus answer
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata               <= 32'h0000_0000;
      rsp_ready           <= 1'b0;
    end
    else
    begin
      rdata               <= next_rdata;
      rsp_ready           <= next_rsp_ready;
    end
  end

  // outputs straight from flops; pslverr tied low
  assign pad_out             = output_data;
  assign pad_oe_out          = pad_direction;
  assign irq_out             = irq;
  assign apb_rsp_out.pready  = rsp_ready;
  assign apb_rsp_out.pslverr = 1'b0;
  assign apb_rsp_out.prdata  = rdata;
endmodule
`default_nettype wire

/* core/gpioi_defs.svh */
// register offsets, widths and reset values of the gpio port
`ifndef GPIOI_DEFS_SVH
`define GPIOI_DEFS_SVH
`define GPIOI_ADDR_W         7
`define GPIOI_OFF_OUT_DATA   7'h00
`define GPIOI_OFF_DIRECTION  7'h04
`define GPIOI_OFF_IRQ_EN     7'h30
`define GPIOI_OFF_IRQ_MASK   7'h34
`define GPIOI_OFF_IRQ_TYPE   7'h38
`define GPIOI_OFF_IRQ_POL    7'h3C
`define GPIOI_OFF_MSK_STAT   7'h40
`define GPIOI_OFF_RAW_STAT   7'h44
`define GPIOI_OFF_DEBOUNCE   7'h48
`define GPIOI_OFF_EDGE_CLR   7'h4C
`define GPIOI_OFF_PAD_IN     7'h50
`define GPIOI_OFF_LVL_SYNC   7'h60
`define GPIOI_RESET_WORD     32'h0000_0000
`define GPIOI_SYNC_BIT       0
`endif

/* core/gpioi_pkg.sv */
// types shared by the gpio port files
package gpioi_pkg;
  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [6:0]  paddr;
    logic [31:0] pwdata;
  } gpioi_apb_req_s;
  // apb answer bundle
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } gpioi_apb_rsp_s;
endpackage

/* core/gpioi_input_cond.sv */
// one pad's input conditioning: synchroniser and two-sample debounce
`timescale 1ns/1ps
`default_nettype none
module gpioi_input_cond (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  // pad and controls
  input  wire logic pad_in,
  input  wire logic debounce_en_in,
  // conditioned levels
  output logic      sync_out,
  output logic      cond_out
);
  logic meta;
  logic sync;
  logic deb;
  logic cond_q;
  logic next_meta;
  logic next_sync;
  logic next_deb;
  logic next_cond_q;

  // next values: deb holds the previous synced sample, cond_q the last agreed level
  always_comb
  begin
    next_meta   = pad_in;
    next_sync   = meta;
    next_deb    = sync;
    next_cond_q = (sync == deb) ? sync : cond_q;
  end

  // register stage
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      deb    <= 1'b0;
      cond_q <= 1'b0;
    end
    else
    begin
      meta   <= next_meta;
      sync   <= next_sync;
      deb    <= next_deb;
      cond_q <= next_cond_q;
    end
  end

  assign sync_out = sync;
  // debounced level moves only after two equal samples, so one-edge pulses are dropped
  assign cond_out = debounce_en_in ? next_cond_q : sync;
endmodule
`default_nettype wire

/* sim/gpioi_port_properties.sv */
// pin-level assertions for the gpio port
`timescale 1ns/1ps
`default_nettype none
module gpioi_checker #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic                      core_clk_in,
  input wire logic                      reset_n_in,
  // bus
  input wire gpioi_pkg::gpioi_apb_req_s apb_req_in,
  input wire gpioi_pkg::gpioi_apb_rsp_s apb_rsp_out,
  // pads and interrupt
  input wire logic [WIDTH-1:0]          pad_in,
  input wire logic [WIDTH-1:0]          pad_out,
  input wire logic [WIDTH-1:0]          pad_oe_out,
  input wire logic                      irq_out
);
  import gpioi_pkg::*;
  logic setup;
  logic wr_out;
  logic wr_dir;
  // decoded bus phases
  assign setup  = apb_req_in.psel && !apb_req_in.penable;
  assign wr_out = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite
                  && apb_req_in.paddr == 7'h00;
  assign wr_dir = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite
                  && apb_req_in.paddr == 7'h04;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  no_error_a: assert property (apb_rsp_out.pslverr == 1'b0)
    else $error("bus error response seen");
  ready_setup_a: assert property (setup |=> apb_rsp_out.pready)
    else $error("no ready in access cycle");
  ready_idle_a: assert property (!apb_req_in.psel |=> !apb_rsp_out.pready)
    else $error("ready without select");
  idle_data_a: assert property (!apb_rsp_out.pready |-> apb_rsp_out.prdata == 32'h0)
    else $error("read data outside access");
  data_write_a: assert property (wr_out |=> pad_out == $past(apb_req_in.pwdata))
    else $error("pad data not written value");
  dir_write_a: assert property (wr_dir |=> pad_oe_out == $past(apb_req_in.pwdata))
    else $error("direction not written value");
  data_hold_a: assert property (!wr_out |=> $stable(pad_out))
    else $error("pad data moved without write");
  dir_hold_a: assert property (!wr_dir |=> $stable(pad_oe_out))
    else $error("direction moved without write");
  // main scenarios reached
  cv_dir: cover property (wr_dir);
  cv_read: cover property (setup ##1 !apb_req_in.pwrite);
  cv_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

/* sim/gpioi_pad_model.sv */
// outside pads: port drives its output bits, the world the rest
`timescale 1ns/1ps
`default_nettype none
module gpioi_pad_model #(
  parameter int WIDTH = 32
) (
  // port side
  input  wire logic [WIDTH-1:0] drive_in,
  input  wire logic [WIDTH-1:0] enable_in,
  // outside world
  input  wire logic [WIDTH-1:0] ext_in,
  output logic      [WIDTH-1:0] level_out
);
  // a driven pad shows the port's data, an input pad the outside level
  assign level_out = (drive_in & enable_in) | (ext_in & ~enable_in);
endmodule
`default_nettype wire

/* sim/gpio_port_with_interrupts_bench.sv */
// self-checking bench for the gpio port
`timescale 1ns/1ps
`default_nettype none
module gpio_port_with_interrupts_bench;
  import gpioi_pkg::*;
  logic clk;
  logic reset_n;
  gpioi_apb_req_s req;
  gpioi_apb_rsp_s rsp;
  logic [31:0] ext, lvl, po, poe, r, b, d, seed;
  logic irq;
  logic [6:0] offs [13] = '{7'h00, 7'h04, 7'h30, 7'h34, 7'h38, 7'h3C, 7'h40, 7'h44,
                            7'h48, 7'h4C, 7'h50, 7'h60, 7'h7C};
  logic [6:0] rw [7] = '{7'h00, 7'h04, 7'h30, 7'h34, 7'h38, 7'h3C, 7'h48};
  int bad_count, compares, md;
  gpioi_port DUT (.core_clk_in(clk), .reset_n_in(reset_n), .apb_req_in(req),
    .apb_rsp_out(rsp), .pad_in(lvl), .pad_out(po), .pad_oe_out(poe), .irq_out(irq));
  gpioi_pad_model u_pad (.drive_in(po), .enable_in(poe), .ext_in(ext), .level_out(lvl));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access, hold until ready
  task automatic apb(input logic w, input logic [6:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(negedge clk);
    req = '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: v};
    @(negedge clk);
    req.penable = 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        bad_count++;
        final_report();
      end
      @(posedge clk);
    end
    r = rsp.prdata;
    @(negedge clk);
    req.psel = 1'b0;
    req.penable = 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rc(input logic [6:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // main sequence
  initial
  begin
    req = '0;
    ext = '0;
    reset_n = 1'b0;
    seed = 32'd28382;
    wt(8);
    reset_n = 1'b1;
    foreach (offs[i]) rc(offs[i], 32'h0);
    $display("reset values done");
    foreach (offs[i]) wr(offs[i] ^ 7'h00, 32'h0);
    wr(7'h50, 32'hFFFF_FFFF);
    wr(7'h44, 32'hFFFF_FFFF);
    rc(7'h50, 32'h0);
    rc(7'h44, 32'h0);
    foreach (rw[i])
    begin
      seed = nx(seed);
      wr(rw[i], seed);
      rc(rw[i], seed);
      if (i == 1) chk(poe, seed);
      if (i == 0) chk(po, seed);
      wr(rw[i], 32'h0);
    end
    wr(7'h60, 32'hFFFF_FFFF);
    rc(7'h60, 32'h1);
    wr(7'h60, 32'h0);
    $display("register access done");
    repeat (4)
    begin
      seed = nx(seed);
      d = nx(seed);
      wr(7'h00, seed);
      wr(7'h04, d);
      @(negedge clk) ext = nx(d);
      wt(4);
      rc(7'h50, (seed & d) | (ext & ~d));
    end
    wr(7'h04, 32'h0);
    $display("pad read done");
    for (md = 0; md < 4; md++)
    begin
      seed = nx(seed);
      b = 32'h1 << seed[4:0];
      ext = md[0] ? ext & ~b : ext | b;
      wr(7'h38, md[1] ? b : 32'h0);
      wr(7'h3C, md[0] ? b : 32'h0);
      wr(7'h30, b);
      wt(6);
      rc(7'h44, 32'h0);
      ext = ext ^ b;
      wt(6);
      rc(7'h40, b);
      chk({31'h0, irq}, 32'h1);
      wr(7'h4C, b);
      rc(7'h44, md[1] ? 32'h0 : b);
      rc(7'h44, md[1] ? 32'h0 : b);
      ext = ext ^ b;
      wt(6);
      rc(7'h44, 32'h0);
      ext = ext ^ b;
      wt(6);
      wr(7'h34, b);
      rc(7'h40, 32'h0);
      rc(7'h44, b);
      chk({31'h0, irq}, 32'h0);
      wr(7'h30, 32'h0);
      rc(7'h44, 32'h0);
      wr(7'h34, 32'h0);
    end
    $display("interrupt modes done");
    ext = '0;
    b = 32'h20;
    wr(7'h38, b);
    wr(7'h3C, b);
    wr(7'h48, b);
    wr(7'h30, b);
    wt(6);
    ext = b;
    wt(1);
    ext = '0;
    wt(6);
    rc(7'h44, 32'h0);
    ext = b;
    wt(3);
    ext = '0;
    wt(6);
    rc(7'h44, b);
    wr(7'h4C, b);
    wr(7'h48, 32'h0);
    ext = b;
    wt(1);
    ext = '0;
    wt(6);
    rc(7'h44, b);
    wr(7'h00, 32'h0);
    wr(7'h04, b);
    rc(7'h44, b);
    wr(7'h4C, b);
    wr(7'h00, b);
    wt(6);
    rc(7'h44, 32'h0);
    $display("debounce and direction done");
    final_report();
  end
endmodule
bind gpioi_port gpioi_checker #(.WIDTH(WIDTH)) u_chk (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out), .irq_out(irq_out));
`default_nettype wire
